//--- verilog/gas_cmd_pkg.sv
// Shared constants for the gas sensor command interpreter.
// Assumes a 40 MHz core clock and a free-running link sampling clock.
package gas_cmd_pkg;

  // ---------------------------------------------------------------
  // Bus address and command codes
  // ---------------------------------------------------------------
  localparam logic [6:0]  DEV_ADDR      = 7'h29;
  localparam logic [15:0] CMD_SET_TEMP  = 16'h361E;
  localparam logic [15:0] CMD_SET_PRESS = 16'h362F;
  localparam logic [15:0] CMD_MEASURE   = 16'h3639;
  localparam logic [15:0] CMD_FRC       = 16'h3661;
  localparam logic [15:0] CMD_ASC_ON    = 16'h3FEF;
  localparam logic [15:0] CMD_ASC_OFF   = 16'h3F6E;
  localparam logic [15:0] CMD_CRC_OFF   = 16'h3768;

  // ---------------------------------------------------------------
  // Reset values and checksum
  // ---------------------------------------------------------------
  localparam logic [15:0] PRESS_DEFAULT = 16'h03F5;
  localparam logic [15:0] FRC_REF_DEF   = 16'h0000;
  localparam logic [15:0] RESERVED_WORD = 16'h0000;
  localparam logic [15:0] TEMP_DEFAULT  = 16'h0000;
  localparam logic [7:0]  CRC_POLY      = 8'h31;
  localparam logic [7:0]  CRC_INIT      = 8'hFF;
  localparam logic [7:0]  IDLE_BYTE     = 8'hFF;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int MEAS_TIME_MS  = 66;
  localparam int CLK_PERIOD_NS = 25;
  localparam int MEAS_CYCLES   = (MEAS_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int MEAS_CNT_W    = 22;

  // ---------------------------------------------------------------
  // Events passed from the link to the core
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    EV_NONE,
    EV_MEASURE,
    EV_FRC,
    EV_TEMP,
    EV_PRESS,
    EV_ASC_ON,
    EV_ASC_OFF
  } cmd_ev_t;

endpackage

//--- verilog/crc8_word.sv
// CRC-8 of one 16-bit word, most significant bit first.
// Purely combinational; the caller registers what it needs.
`timescale 1ns/10ps
module crc8_word #(
  parameter logic [7:0] POLY = 8'h31,
  parameter logic [7:0] INIT = 8'hFF
) (
  input  wire logic [15:0] data,
  output logic      [7:0]  crc
);

  always_comb
  begin
    crc = INIT;
    for (int i = 15; i >= 0; i--)
    begin
      if (crc[7] ^ data[i])
        crc = {crc[6:0], 1'b0} ^ POLY;
      else
        crc = {crc[6:0], 1'b0};
    end
  end

endmodule // crc8_word

//--- verilog/gas_cmd_top.sv
// Command interpreter of the gas sensor: two-wire target on link_clk,
// compensation state and single-shot measurement timing on clk.
// Assumes scl and sda arrive unsynchronised; sda is open drain outside.
`timescale 1ns/10ps

// What this block does
// - Code 361E with signed 16-bit word sets the compensation temperature.
// - After reset the internal temperature is used until an override is accepted.
// - Accepted temperature or pressure values hold until rewritten.
// - Bad temperature checksum: NACK, discard, revert to internal temperature.
// - Code 362F sets unsigned pressure; default after reset is 1013 mbar.
// - Bad pressure checksum: NACK, ignore, keep previous pressure.
// - Code 3639 starts one measurement, ready within 66 ms.
// - Read header is NACKed until a result is ready.
// - Readout: concentration, temperature, reserved, each MSB first plus checksum.
// - Host may end the readout after any byte with NACK and STOP.
// - Readout temperature is the override if set, else internal reading.
// - Code 3661 with a reference forces recalibration to that value.
// - Recalibration without argument uses reference zero.
// - Recalibration also starts a normal measurement.
// - Bad recalibration checksum: NACK, no recalibration, still measure.
// - Codes 3FEF and 3F6E switch self-calibration on and off; off at reset.
// - Commands are 16-bit; data words carry an 8-bit checksum.
// - Target address 29 hex; clock is never stretched.
// - Code 3768 turns checksums off; reset turns them back on.
module gas_cmd_top #(
  parameter int MEAS_CYCLES = gas_cmd_pkg::MEAS_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        link_clk,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic [15:0] internal_temp,
  input  wire logic [15:0] meas_conc,
  output logic      [15:0] temp_comp,
  output logic             temp_override_active,
  output logic      [15:0] pressure_comp,
  output logic             auto_self_calibration_en,
  output logic      [15:0] forced_recalibration_ref,
  output logic             forced_recalibration_strobe,
  output logic             meas_start,
  output logic             meas_busy
);

  // ---------------------------------------------------------------
  // Link domain: synchronisers
  // ---------------------------------------------------------------
  logic       lrst_s1, lrst_n;
  logic [2:0] scl_s, sda_s;
  logic       rdy_s1, rdy_s2;
  logic       ready_q;

  always_ff @(posedge link_clk)
  begin
    lrst_s1 <= resetn;
    lrst_n  <= lrst_s1;
    scl_s   <= {scl_s[1:0], scl_i};
    sda_s   <= {sda_s[1:0], sda_i};
    rdy_s1  <= ready_q;
    rdy_s2  <= rdy_s1;
  end

  logic scl_rise, scl_fall, start_det, stop_det, sda_v;
  assign sda_v     = sda_s[1];
  assign scl_rise  = scl_s[1] & ~scl_s[2];
  assign scl_fall  = ~scl_s[1] & scl_s[2];
  assign start_det = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign stop_det  = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

  // ---------------------------------------------------------------
  // Link domain: target state machine
  // ---------------------------------------------------------------
  typedef enum {L_IDLE, L_ADDR, L_WR, L_ACK, L_RD, L_RACK} link_st_t;
  link_st_t    st_q;
  logic [3:0]  bit_q;
  logic [7:0]  sh_q;
  logic [2:0]  wr_cnt_q;
  logic        wr_mode_q, rd_mode_q, crc_en_q, rd_tgl_q;
  logic [15:0] cmd_q, arg_q;
  logic [7:0]  crc_rx_q;
  logic [1:0]  word_q, pos_q;
  logic [15:0] res_conc_q, res_temp_q, cur_word;
  logic [7:0]  arg_crc, word_crc, cur_byte;
  logic        commit;

  crc8_word #(.POLY(gas_cmd_pkg::CRC_POLY), .INIT(gas_cmd_pkg::CRC_INIT)) u_crc_arg (
    .data (arg_q),
    .crc  (arg_crc)
  );
  crc8_word #(.POLY(gas_cmd_pkg::CRC_POLY), .INIT(gas_cmd_pkg::CRC_INIT)) u_crc_rd (
    .data (cur_word),
    .crc  (word_crc)
  );

  always_comb
  begin
    unique case (word_q)
      2'h0:    cur_word = res_conc_q;
      2'h1:    cur_word = res_temp_q;
      default: cur_word = gas_cmd_pkg::RESERVED_WORD;
    endcase
    if (word_q == 2'h3)
      cur_byte = gas_cmd_pkg::IDLE_BYTE;
    else if (pos_q == 2'h0)
      cur_byte = cur_word[15:8];
    else if (pos_q == 2'h1)
      cur_byte = cur_word[7:0];
    else
      cur_byte = word_crc;
  end

  assign commit = (start_det | stop_det) & wr_mode_q & (wr_cnt_q >= 3'h2);

  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
    begin
      st_q      <= L_IDLE;
      bit_q     <= 4'h0;
      sh_q      <= 8'h00;
      wr_cnt_q  <= 3'h0;
      wr_mode_q <= 1'b0;
      rd_mode_q <= 1'b0;
      rd_tgl_q  <= 1'b0;
      cmd_q     <= 16'h0000;
      arg_q     <= 16'h0000;
      crc_rx_q  <= 8'h00;
      word_q    <= 2'h0;
      pos_q     <= 2'h0;
      sda_oe    <= 1'b0;
    end
    else if (start_det)
    begin
      st_q      <= L_ADDR;
      bit_q     <= 4'h0;
      wr_cnt_q  <= 3'h0;
      wr_mode_q <= 1'b0;
      sda_oe    <= 1'b0;
    end
    else if (stop_det)
    begin
      st_q      <= L_IDLE;
      wr_mode_q <= 1'b0;
      sda_oe    <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (st_q == L_ADDR || st_q == L_WR)
      begin
        sh_q  <= {sh_q[6:0], sda_v};
        bit_q <= bit_q + 4'h1;
      end
      else if (st_q == L_RACK && sda_v)
        st_q <= L_IDLE;
    end
    else if (scl_fall)
    begin
      unique case (st_q)
        L_IDLE: ;
        L_ADDR:
          if (bit_q == 4'h8)
          begin
            if (sh_q[7:1] == gas_cmd_pkg::DEV_ADDR && (!sh_q[0] || rdy_s2))
            begin
              st_q      <= L_ACK;
              sda_oe    <= 1'b1;
              rd_mode_q <= sh_q[0];
              wr_mode_q <= ~sh_q[0];
              word_q    <= 2'h0;
              pos_q     <= 2'h0;
              rd_tgl_q  <= rd_tgl_q ^ sh_q[0];
            end
            else
              st_q <= L_IDLE;
          end
        L_WR:
          if (bit_q == 4'h8)
          begin
            unique case (wr_cnt_q)
              3'h0:    cmd_q[15:8] <= sh_q;
              3'h1:    cmd_q[7:0]  <= sh_q;
              3'h2:    arg_q[15:8] <= sh_q;
              3'h3:    arg_q[7:0]  <= sh_q;
              default: crc_rx_q    <= sh_q;
            endcase
            if (wr_cnt_q != 3'h7)
              wr_cnt_q <= wr_cnt_q + 3'h1;
            if (wr_cnt_q < 3'h4 || (wr_cnt_q == 3'h4 && (!crc_en_q || sh_q == arg_crc)))
            begin
              st_q   <= L_ACK;
              sda_oe <= 1'b1;
            end
            else
              st_q <= L_IDLE;
          end
        L_ACK:
        begin
          bit_q <= 4'h0;
          if (rd_mode_q)
          begin
            st_q   <= L_RD;
            sda_oe <= ~cur_byte[7];
          end
          else
          begin
            st_q   <= L_WR;
            sda_oe <= 1'b0;
          end
        end
        L_RD:
          if (bit_q == 4'h7)
          begin
            st_q   <= L_RACK;
            sda_oe <= 1'b0;
            if (pos_q == 2'h2 || (pos_q == 2'h1 && !crc_en_q))
            begin
              pos_q  <= 2'h0;
              word_q <= (word_q == 2'h3) ? 2'h3 : word_q + 2'h1;
            end
            else
              pos_q <= pos_q + 2'h1;
          end
          else
          begin
            sda_oe <= ~cur_byte[3'h6 - bit_q[2:0]];
            bit_q  <= bit_q + 4'h1;
          end
        L_RACK:
        begin
          st_q   <= L_RD;
          bit_q  <= 4'h0;
          sda_oe <= ~cur_byte[7];
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Link domain: command decode and hand-off
  // ---------------------------------------------------------------
  gas_cmd_pkg::cmd_ev_t ev_kind_q, ev_dec;
  logic        ev_tgl_q, ev_ok_q, arg_in, arg_good;
  logic [15:0] ev_arg_q;

  assign arg_in   = wr_cnt_q >= 3'h4;
  assign arg_good = arg_in & (!crc_en_q | (wr_cnt_q >= 3'h5 && crc_rx_q == arg_crc));

  always_comb
  begin
    unique case (cmd_q)
      gas_cmd_pkg::CMD_MEASURE:   ev_dec = gas_cmd_pkg::EV_MEASURE;
      gas_cmd_pkg::CMD_FRC:       ev_dec = gas_cmd_pkg::EV_FRC;
      gas_cmd_pkg::CMD_SET_TEMP:  ev_dec = arg_in ? gas_cmd_pkg::EV_TEMP : gas_cmd_pkg::EV_NONE;
      gas_cmd_pkg::CMD_SET_PRESS: ev_dec = arg_in ? gas_cmd_pkg::EV_PRESS : gas_cmd_pkg::EV_NONE;
      gas_cmd_pkg::CMD_ASC_ON:    ev_dec = gas_cmd_pkg::EV_ASC_ON;
      gas_cmd_pkg::CMD_ASC_OFF:   ev_dec = gas_cmd_pkg::EV_ASC_OFF;
      default:                    ev_dec = gas_cmd_pkg::EV_NONE;
    endcase
  end

  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
    begin
      ev_tgl_q  <= 1'b0;
      ev_kind_q <= gas_cmd_pkg::EV_NONE;
      ev_ok_q   <= 1'b0;
      ev_arg_q  <= 16'h0000;
      crc_en_q  <= 1'b1;
    end
    else if (commit)
    begin
      if (cmd_q == gas_cmd_pkg::CMD_CRC_OFF)
        crc_en_q <= 1'b0;
      if (ev_dec != gas_cmd_pkg::EV_NONE)
      begin
        ev_tgl_q  <= ~ev_tgl_q;
        ev_kind_q <= ev_dec;
        ev_ok_q   <= arg_in ? arg_good : (ev_dec == gas_cmd_pkg::EV_FRC);
        ev_arg_q  <= arg_in ? arg_q : gas_cmd_pkg::FRC_REF_DEF;
      end
    end
  end

  assign sda_o = 1'b0;

  // ---------------------------------------------------------------
  // Core domain: event crossing
  // ---------------------------------------------------------------
  logic [2:0] ev_s, rd_s;
  logic       ev_p, rd_p;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ev_s <= 3'h0;
      rd_s <= 3'h0;
    end
    else
    begin
      ev_s <= {ev_s[1:0], ev_tgl_q};
      rd_s <= {rd_s[1:0], rd_tgl_q};
    end
  end

  assign ev_p = ev_s[1] ^ ev_s[2];
  assign rd_p = rd_s[1] ^ rd_s[2];

  // ---------------------------------------------------------------
  // Core domain: compensation and calibration state
  // ---------------------------------------------------------------
  logic [15:0] temp_val_q;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      temp_override_active        <= 1'b0;
      temp_val_q                  <= gas_cmd_pkg::TEMP_DEFAULT;
      temp_comp                   <= gas_cmd_pkg::TEMP_DEFAULT;
      pressure_comp               <= gas_cmd_pkg::PRESS_DEFAULT;
      auto_self_calibration_en    <= 1'b0;
      forced_recalibration_ref    <= gas_cmd_pkg::FRC_REF_DEF;
      forced_recalibration_strobe <= 1'b0;
    end
    else
    begin
      forced_recalibration_strobe <= 1'b0;
      temp_comp <= temp_override_active ? temp_val_q : internal_temp;
      if (ev_p && ev_kind_q == gas_cmd_pkg::EV_TEMP)
      begin
        temp_override_active <= ev_ok_q;
        if (ev_ok_q)
          temp_val_q <= ev_arg_q;
      end
      if (ev_p && ev_kind_q == gas_cmd_pkg::EV_PRESS && ev_ok_q)
        pressure_comp <= ev_arg_q;
      if (ev_p && ev_kind_q == gas_cmd_pkg::EV_ASC_ON)
        auto_self_calibration_en <= 1'b1;
      if (ev_p && ev_kind_q == gas_cmd_pkg::EV_ASC_OFF)
        auto_self_calibration_en <= 1'b0;
      if (ev_p && ev_kind_q == gas_cmd_pkg::EV_FRC && ev_ok_q)
      begin
        forced_recalibration_ref    <= ev_arg_q;
        forced_recalibration_strobe <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Core domain: measurement timing and result
  // ---------------------------------------------------------------
  logic [gas_cmd_pkg::MEAS_CNT_W-1:0] cnt_q;
  logic        sel_q, go, done;
  logic [15:0] snap_q;

  assign go   = ev_p & ~meas_busy & (ev_kind_q == gas_cmd_pkg::EV_MEASURE || ev_kind_q == gas_cmd_pkg::EV_FRC);
  assign done = meas_busy & (cnt_q == gas_cmd_pkg::MEAS_CNT_W'(MEAS_CYCLES - 1));

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      meas_busy  <= 1'b0;
      meas_start <= 1'b0;
      ready_q    <= 1'b0;
      cnt_q      <= '0;
      sel_q      <= 1'b0;
      snap_q     <= 16'h0000;
      res_conc_q <= 16'h0000;
      res_temp_q <= 16'h0000;
    end
    else
    begin
      meas_start <= go;
      if (rd_p)
        ready_q <= 1'b0;
      if (go)
      begin
        meas_busy <= 1'b1;
        ready_q   <= 1'b0;
        cnt_q     <= '0;
        sel_q     <= temp_override_active;
        snap_q    <= temp_val_q;
      end
      else if (done)
      begin
        meas_busy  <= 1'b0;
        ready_q    <= 1'b1;
        res_conc_q <= meas_conc;
        res_temp_q <= sel_q ? snap_q : internal_temp;
      end
      else if (meas_busy)
        cnt_q <= cnt_q + gas_cmd_pkg::MEAS_CNT_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_PRESS_RESET: assert property (@(posedge clk) !resetn |=> pressure_comp == gas_cmd_pkg::PRESS_DEFAULT)
    else $error("pressure not at default after reset");
  AST_PRESS_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    !(ev_p && ev_kind_q == gas_cmd_pkg::EV_PRESS && ev_ok_q) |=> $stable(pressure_comp))
    else $error("pressure changed without accepted write");
  AST_PRESS_BAD: assert property (@(posedge clk) disable iff (!resetn)
    ev_p && ev_kind_q == gas_cmd_pkg::EV_PRESS && !ev_ok_q |=> $stable(pressure_comp))
    else $error("bad pressure write changed value");
  AST_TEMP_BAD: assert property (@(posedge clk) disable iff (!resetn)
    ev_p && ev_kind_q == gas_cmd_pkg::EV_TEMP && !ev_ok_q |=> !temp_override_active ##2 temp_comp == $past(internal_temp))
    else $error("bad temperature write kept override");
  AST_MEAS_DONE: assert property (@(posedge clk) disable iff (!resetn)
    meas_busy && cnt_q == gas_cmd_pkg::MEAS_CNT_W'(MEAS_CYCLES - 1) |=> ready_q && !meas_busy)
    else $error("measurement did not finish on time");
  AST_FRC_MEAS: assert property (@(posedge clk) disable iff (!resetn)
    ev_p && ev_kind_q == gas_cmd_pkg::EV_FRC && !meas_busy |=> meas_busy && meas_start)
    else $error("recalibration did not start a measurement");
  AST_FRC_BAD: assert property (@(posedge clk) disable iff (!resetn)
    ev_p && ev_kind_q == gas_cmd_pkg::EV_FRC && !ev_ok_q |=> !forced_recalibration_strobe)
    else $error("recalibration applied despite bad argument");
  AST_ASC_ON: assert property (@(posedge clk) disable iff (!resetn)
    ev_p && ev_kind_q == gas_cmd_pkg::EV_ASC_ON |=> auto_self_calibration_en [*2])
    else $error("self-calibration not enabled");
  AST_TEMP_WORD: assert property (@(posedge clk) disable iff (!resetn)
    $rose(ready_q) && sel_q |-> res_temp_q == snap_q)
    else $error("readout temperature is not the override");

endmodule // gas_cmd_top

//--- verif/i2c_host.sv
// Behavioural two-wire controller playing the host microcontroller.
// Assumes a pull-up on sda outside; scl is driven directly.
`timescale 1ns/10ps
module i2c_host (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  localparam int HALF = 200;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One bit; data moves 50 ns after scl falls
  task automatic bit_x(input logic b, output logic r);
    sda_low = !b;
    #HALF scl = 1'b1;
    #HALF r = sda;
    scl = 1'b0;
    #50;
  endtask
  task automatic start();
    sda_low = 1'b0;
    #HALF scl = 1'b1;
    #HALF sda_low = 1'b1;
    #HALF scl = 1'b0;
    #50;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #HALF scl = 1'b1;
    #HALF sda_low = 1'b0;
    #HALF;
  endtask
  task automatic wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  // Host NACK on the last byte ends the readout
  task automatic rd(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    bit_x(last, r);
  endtask
endmodule // i2c_host

//--- verif/tb_top.sv
// Self-checking bench for the gas sensor command interpreter.
// Assumes i2c_host and the design package in the same compile.
`timescale 1ns/10ps
module tb_top;
  localparam int MC = 200;
  logic        clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        scl, host_low, sda_o, sda_oe, ovr, auto_self_calibration, frc_stb, m_start, busy;
  logic [15:0] itemp = 16'h0000;
  logic [15:0] conc = 16'h0000;
  logic [15:0] temp_comp, press, frc_ref;
  logic [15:0] exp_q[$];
  logic [15:0] act_q[$];
  logic [7:0]  rb[9];
  int          error_cnt = 0;
  int          comparisons = 0;
  int          starts = 0;
  int          strobes = 0;
  wire         sda = !(host_low | (sda_oe & !sda_o));

  always #12.5 clk = !clk;
  always #7.5 link_clk = !link_clk;

  i2c_host i2c_host_i (.scl(scl), .sda_low(host_low), .sda(sda));
  gas_cmd_top #(.MEAS_CYCLES(MC)) gas_cmd_top_i (
    .clk(clk), .resetn(resetn), .link_clk(link_clk), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .internal_temp(itemp), .meas_conc(conc),
    .temp_comp(temp_comp), .temp_override_active(ovr), .pressure_comp(press),
    .auto_self_calibration_en(auto_self_calibration), .forced_recalibration_ref(frc_ref),
    .forced_recalibration_strobe(frc_stb), .meas_start(m_start), .meas_busy(busy));

  // ------------------------------------------------------------
  // Result monitor
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    starts <= starts + int'(m_start === 1'b1);
    strobes <= strobes + int'(frc_stb === 1'b1);
    if (act_q.size() > 0)
    begin
      comparisons++;
      if (act_q[0] !== exp_q[0])
      begin
        error_cnt++;
        $display("mismatch t=%0t exp=%h act=%h", $time, exp_q[0], act_q[0]);
      end
      void'(act_q.pop_front());
      void'(exp_q.pop_front());
    end
  end

  task automatic chk(input logic [15:0] e, input logic [15:0] a);
    exp_q.push_back(e);
    act_q.push_back(a);
  endtask

  task automatic final_report();
    repeat (20) @(posedge clk);
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = gas_cmd_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--)
      c = (c[7] ^ d[i]) ? {c[6:0], 1'b0} ^ gas_cmd_pkg::CRC_POLY : {c[6:0], 1'b0};
    return c;
  endfunction

  // ------------------------------------------------------------
  // Bus sequences
  // ------------------------------------------------------------
  task automatic cmd(input logic [15:0] code, input int n, input logic [15:0] arg,
                     input logic bad, output logic crc_ack);
    logic [7:0] by[6];
    logic       a;
    by = '{8'h52, code[15:8], code[7:0], arg[15:8], arg[7:0], crc8(arg) ^ {7'h00, bad}};
    crc_ack = 1'b1;
    i2c_host_i.start();
    for (int i = 0; i < 3 + n; i++)
    begin
      i2c_host_i.wr(by[i], a);
      if (i < 5) chk(16'h0001, 16'(a));
      else crc_ack = a;
    end
    i2c_host_i.stop();
    repeat (20) @(posedge clk);
  endtask

  task automatic rd(input int n, output logic ok);
    logic a;
    i2c_host_i.start();
    i2c_host_i.wr(8'h53, a);
    ok = a;
    for (int i = 0; i < n && a; i++) i2c_host_i.rd(i == n - 1, rb[i]);
    i2c_host_i.stop();
  endtask

  task automatic meas(input logic [15:0] code, input int n, input logic [15:0] arg,
                      input logic bad, input logic [15:0] tmp, input int nr, input logic crc_on);
    logic [15:0] w[3];
    logic [7:0]  ex[$];
    logic        a;
    int          s;
    @(posedge clk);
    #1 conc = 16'($urandom);
    s = starts;
    w = '{conc, tmp, gas_cmd_pkg::RESERVED_WORD};
    for (int i = 0; i < 3; i++)
    begin
      ex.push_back(w[i][15:8]);
      ex.push_back(w[i][7:0]);
      if (crc_on) ex.push_back(crc8(w[i]));
    end
    cmd(code, n, arg, bad, a);
    if (n == 3) chk(16'(!bad), 16'(a));
    chk(16'(s + 1), 16'(starts));
    for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge clk);
    rd(nr, a);
    chk(16'h0001, 16'(a));
    for (int i = 0; i < nr; i++) chk(16'(ex[i]), 16'(rb[i]));
    rd(1, a);
    chk(16'h0000, 16'(a));
  endtask

  initial
  begin
    #2ms;
    error_cnt++;
    final_report();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic        a;
    logic [15:0] p, t;
    int          s;
    void'($urandom(32'h7C9A184D));
    @(posedge clk);
    #1 itemp = 16'($urandom);
    repeat (8) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (10) @(posedge clk);
    chk(gas_cmd_pkg::PRESS_DEFAULT, press);
    chk(16'h0000, 16'(auto_self_calibration));
    chk(itemp, temp_comp);
    chk(16'h0000, 16'(ovr));
    rd(1, a);
    chk(16'h0000, 16'(a));
    i2c_host_i.start();
    i2c_host_i.wr({gas_cmd_pkg::DEV_ADDR ^ 7'h01, 1'b0}, a);
    i2c_host_i.stop();
    chk(16'h0000, 16'(a));
    p = 16'(600 + $urandom_range(600));
    cmd(gas_cmd_pkg::CMD_SET_PRESS, 3, p, 1'b0, a);
    chk(p, press);
    cmd(gas_cmd_pkg::CMD_SET_PRESS, 3, p + 16'h0001, 1'b1, a);
    chk(16'h0000, 16'(a));
    t = 16'($urandom);
    cmd(gas_cmd_pkg::CMD_SET_TEMP, 3, t, 1'b0, a);
    chk(t, temp_comp);
    chk(16'h0001, 16'(ovr));
    chk(p, press);
    meas(gas_cmd_pkg::CMD_MEASURE, 0, 16'h0000, 1'b0, t, 9, 1'b1);
    cmd(gas_cmd_pkg::CMD_SET_TEMP, 3, ~t, 1'b1, a);
    chk(16'h0000, 16'(a));
    chk(itemp, temp_comp);
    chk(16'h0000, 16'(ovr));
    meas(gas_cmd_pkg::CMD_MEASURE, 0, 16'h0000, 1'b0, itemp, 2, 1'b1);
    s = strobes;
    meas(gas_cmd_pkg::CMD_FRC, 3, t, 1'b0, itemp, 9, 1'b1);
    chk(t, frc_ref);
    meas(gas_cmd_pkg::CMD_FRC, 3, ~t, 1'b1, itemp, 3, 1'b1);
    chk(t, frc_ref);
    meas(gas_cmd_pkg::CMD_FRC, 0, t, 1'b0, itemp, 1, 1'b1);
    chk(gas_cmd_pkg::FRC_REF_DEF, frc_ref);
    chk(16'(s + 2), 16'(strobes));
    cmd(gas_cmd_pkg::CMD_ASC_ON, 0, 16'h0000, 1'b0, a);
    chk(16'h0001, 16'(auto_self_calibration));
    cmd(gas_cmd_pkg::CMD_ASC_OFF, 0, 16'h0000, 1'b0, a);
    chk(16'h0000, 16'(auto_self_calibration));
    cmd(gas_cmd_pkg::CMD_CRC_OFF, 0, 16'h0000, 1'b0, a);
    cmd(gas_cmd_pkg::CMD_SET_PRESS, 2, ~p, 1'b0, a);
    chk(~p, press);
    meas(gas_cmd_pkg::CMD_MEASURE, 0, 16'h0000, 1'b0, itemp, 6, 1'b0);
    final_report();
  end
endmodule // tb_top
